// ===== core/pulse_defs.svh
`ifndef PULSE_DEFS_SVH
`define PULSE_DEFS_SVH

// ----------------------------------------------------------------
// Register indices (byte address is four times the index)
// ----------------------------------------------------------------
`define IDX_LAST_CFG 8'd20
`define IDX_GPIO_CFG 8'd9
`define IDX_SRC_SEL 8'd13
`define IDX_SLOPE0 8'd14
`define IDX_OFFSET0 8'd15
`define IDX_SLOPE1 8'd16
`define IDX_OFFSET1 8'd17
`define IDX_STATUS 8'd32
`define IDX_GPIO_DATA 8'd33

// ----------------------------------------------------------------
// Field positions of the port and pulse configuration word and of the source select
// ----------------------------------------------------------------
`define F_DIR_LSB 0
`define F_PULLUP_LSB 6
`define F_DEBOUNCE_LSB 10
`define F_ROUTE_CD 14
`define F_CAR0_LSB 15
`define F_CAR1_LSB 17
`define F_RES0_LSB 19
`define F_RES1_LSB 22
`define F_PWM0 25
`define F_PWM1 26
`define F_SRC0_LSB 0
`define F_SRC1_LSB 3

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define RST_GPIO_CFG 32'h0000_3fff
`define RST_SRC_SEL 6'h00
`define RST_PARAM 24'h00_0000
`define RST_GPIO_DATA 6'h00

// ----------------------------------------------------------------
// Arithmetic and timing
// ----------------------------------------------------------------
`define MAX_RES_BITS 10
`define SLOPE_FRAC_BITS 16
`define CLK_PERIOD_PS 8000
`define CLK_KHZ (1000000000 / `CLK_PERIOD_PS)
`define CAR_8M_KHZ 8000
`define CAR_1M_KHZ 1000
`define CAR_100K_KHZ 100
`define DEBOUNCE_NS 1000
`define DEBOUNCE_CYCLES ((`DEBOUNCE_NS * 1000 + `CLK_PERIOD_PS - 1) / `CLK_PERIOD_PS)

`endif

// ===== core/pulse_pkg.sv
package pulse_pkg;

    typedef enum logic [1:0] {
        car_8m = 2'b00,
        car_1m = 2'b01,
        car_100k = 2'b10
    } carrier_sel_t;

    typedef logic [23:0] meas_word_t;
    typedef logic [9:0] pulse_code_t;

endpackage

// ===== core/port_debounce.sv
`timescale 1ns/1ps

module port_debounce #(
    parameter int STABLE_CYCLES = 125
) (
    input wire logic clk,
    input wire logic srst,
    input wire logic raw_in,
    input wire logic enable,
    output logic level_out
);
    localparam int CW = $clog2(STABLE_CYCLES + 1);

    logic stable_ff;
    logic [CW-1:0] cnt_ff;

    generate
        if (STABLE_CYCLES < 1) begin : g_bad
            $error("port_debounce: STABLE_CYCLES must be at least 1");
        end
    endgenerate

    // Level accepted after it stays unchanged long enough
    always_ff @(posedge clk) begin
        if (srst) begin
            stable_ff <= 1'b1;
            cnt_ff <= '0;
        end else if (raw_in == stable_ff) begin
            cnt_ff <= '0;
        end else if (cnt_ff == CW'(STABLE_CYCLES - 1)) begin
            stable_ff <= raw_in;
            cnt_ff <= '0;
        end else begin
            cnt_ff <= cnt_ff + 1'b1;
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            level_out <= 1'b1;
        end else begin
            level_out <= enable ? stable_ff : raw_in;
        end
    end
endmodule // port_debounce

// ===== core/pulse_modulator.sv
`timescale 1ns/1ps
`include "pulse_defs.svh"

module pulse_modulator (
    input wire logic clk,
    input wire logic srst,
    input wire logic tick,
    input wire pulse_pkg::pulse_code_t code_in,
    input wire logic [9:0] max_in,
    input wire logic pwm_mode,
    output logic pulse_out
);
    import pulse_pkg::*;

    pulse_code_t code_ff;
    logic [9:0] max_ff;
    logic pwm_ff;
    logic [9:0] cnt_ff;
    logic [9:0] acc_ff;
    logic [10:0] sum;
    logic wrap;

    assign sum = {1'b0, acc_ff} + {1'b0, code_ff};
    assign wrap = (cnt_ff >= max_ff - 10'h001);

    // New code, width and mode latched only at a period boundary
    always_ff @(posedge clk) begin
        if (srst) begin
            code_ff <= '0;
            max_ff <= 10'h3ff;
            pwm_ff <= 1'b0;
            cnt_ff <= '0;
        end else if (tick) begin
            if (wrap) begin
                cnt_ff <= '0;
                code_ff <= code_in;
                max_ff <= max_in;
                pwm_ff <= pwm_mode;
            end else begin
                cnt_ff <= cnt_ff + 10'h001;
            end
        end
    end

    // Ones spread evenly, or one contiguous pulse; 0 gives no ones, max all ones
    always_ff @(posedge clk) begin
        if (srst) begin
            acc_ff <= '0;
            pulse_out <= 1'b0;
        end else if (tick) begin
            if (pwm_ff) begin
                pulse_out <= (cnt_ff < code_ff);
            end else if (sum >= {1'b0, max_ff}) begin
                pulse_out <= 1'b1;
                acc_ff <= 10'(sum - {1'b0, max_ff});
            end else begin
                pulse_out <= 1'b0;
                acc_ff <= sum[9:0];
            end
        end
    end
endmodule // pulse_modulator

// ===== core/pulse_code_output_ports.sv
// What this block does
// - Pulse channels zero and one go to ports a/b, or alternatively c/d.
// - Each channel picks its source result by its own source select.
// - A port carries a pulse only when its direction bit says output.
// - Carrier per channel selectable: 8 MHz, 1 MHz or 100 kHz.
// - Each channel has its own output resolution setting.
// - The 24-bit result becomes a 10-bit code at 10-bit resolution.
// - Code is slope times result plus offset, from parameter registers.
// - Slope and offset are signed values.
// - At 10-bit resolution the code stays within 0 to 1023.
// - Lower resolutions shrink the largest code to the width's maximum.
// - Values outside the valid range are discarded, old code kept.
// - Code zero gives an all-zero pulse stream.
// - Maximum code gives an all-one pulse stream.
// - Input-capable ports have selectable debounce and pull-up.
// - With the four-wire interface active, ports a/b carry select and data out.
// - Configuration and parameter registers read back as zero.
// - Indices 13 to 17 hold source select, slopes and offsets.
//
// The register addresses and the APB register port are this design's own decisions.
`timescale 1ns/1ps
`include "pulse_defs.svh"

module pulse_code_output_ports #(
    parameter int NUM_RESULTS = 8,
    parameter int DEBOUNCE_CYCLES = `DEBOUNCE_CYCLES
) (
    input wire logic clk,
    input wire logic srst,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic [NUM_RESULTS*24-1:0] meas_results,
    input wire logic meas_valid,
    input wire logic spi_active,
    input wire logic spi_data_out,
    input wire logic [5:0] port_in,
    output logic [5:0] port_out,
    output logic [5:0] port_oe,
    output logic [3:0] port_pullup_en,
    output logic spi_select_in
);
    import pulse_pkg::*;

    // ------------------------------------------------------------
    // Elaboration checks
    // ------------------------------------------------------------
    generate
        if (NUM_RESULTS < 1 || NUM_RESULTS > 8) begin : g_bad_num
            $error("NUM_RESULTS must lie between 1 and 8");
        end
        if (DEBOUNCE_CYCLES < 1) begin : g_bad_deb
            $error("DEBOUNCE_CYCLES must be at least 1");
        end
    endgenerate

    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    function automatic logic [3:0] res_width(input logic [2:0] rcode);
        res_width = 4'(`MAX_RES_BITS - int'(rcode));
    endfunction

    function automatic logic [9:0] res_max(input logic [2:0] rcode);
        res_max = 10'((1 << res_width(rcode)) - 1);
    endfunction

    function automatic logic [10:0] linearize(
        input logic signed [23:0] slope,
        input logic signed [23:0] offset,
        input logic [23:0] result,
        input logic [9:0] maxv
    );
        logic signed [48:0] prod;
        logic signed [48:0] scaled;
        logic signed [49:0] sum;
        prod = slope * $signed({1'b0, result});
        scaled = prod >>> `SLOPE_FRAC_BITS;
        sum = {scaled[48], scaled} + {{26{offset[23]}}, offset};
        linearize[10] = !sum[49] && (sum <= $signed({40'h0, maxv}));
        linearize[9:0] = sum[9:0];
    endfunction

    function automatic logic pick_tick(input logic [1:0] sel, input logic [2:0] ticks);
        unique case (sel)
            car_8m: pick_tick = ticks[0];
            car_1m: pick_tick = ticks[1];
            car_100k: pick_tick = ticks[2];
            default: pick_tick = ticks[2];
        endcase
    endfunction

    // ------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------
    logic [31:0] gpio_cfg_ff;
    logic [5:0] src_sel_ff;
    logic signed [23:0] slope0_ff;
    logic signed [23:0] offset0_ff;
    logic signed [23:0] slope1_ff;
    logic signed [23:0] offset1_ff;
    logic [5:0] gpio_data_ff;
    logic [7:0] widx;
    logic addr_ok;
    logic wr_en;

    assign widx = {2'b00, paddr[7:2]};
    assign addr_ok = (paddr[1:0] == 2'b00)
        && (widx <= `IDX_LAST_CFG || widx == `IDX_STATUS || widx == `IDX_GPIO_DATA);
    assign wr_en = psel && penable && pready && pwrite && addr_ok;

    always_ff @(posedge clk) begin
        if (srst) begin
            gpio_cfg_ff <= `RST_GPIO_CFG;
            src_sel_ff <= `RST_SRC_SEL;
            slope0_ff <= `RST_PARAM;
            offset0_ff <= `RST_PARAM;
            slope1_ff <= `RST_PARAM;
            offset1_ff <= `RST_PARAM;
            gpio_data_ff <= `RST_GPIO_DATA;
        end else if (wr_en) begin
            unique case (widx)
                `IDX_GPIO_CFG: gpio_cfg_ff <= pwdata;
                `IDX_SRC_SEL: src_sel_ff <= pwdata[5:0];
                `IDX_SLOPE0: slope0_ff <= pwdata[23:0];
                `IDX_OFFSET0: offset0_ff <= pwdata[23:0];
                `IDX_SLOPE1: slope1_ff <= pwdata[23:0];
                `IDX_OFFSET1: offset1_ff <= pwdata[23:0];
                `IDX_GPIO_DATA: gpio_data_ff <= pwdata[5:0];
                default: gpio_cfg_ff <= gpio_cfg_ff;
            endcase
        end
    end

    // ------------------------------------------------------------
    // Configuration fields
    // ------------------------------------------------------------
    logic [5:0] dir_in;
    logic [3:0] pullup_sel;
    logic [3:0] debounce_sel;
    logic route_cd;
    logic [2:0] res0;
    logic [2:0] res1;
    logic [9:0] max0;
    logic [9:0] max1;

    assign dir_in = gpio_cfg_ff[`F_DIR_LSB +: 6];
    assign pullup_sel = gpio_cfg_ff[`F_PULLUP_LSB +: 4];
    assign debounce_sel = gpio_cfg_ff[`F_DEBOUNCE_LSB +: 4];
    assign route_cd = gpio_cfg_ff[`F_ROUTE_CD];
    assign res0 = gpio_cfg_ff[`F_RES0_LSB +: 3];
    assign res1 = gpio_cfg_ff[`F_RES1_LSB +: 3];
    assign max0 = res_max(res0);
    assign max1 = res_max(res1);

    // ------------------------------------------------------------
    // Linearization
    // ------------------------------------------------------------
    pulse_code_t code0_ff;
    pulse_code_t code1_ff;
    logic drop0_ff;
    logic drop1_ff;
    meas_word_t src0;
    meas_word_t src1;
    logic [10:0] lin0;
    logic [10:0] lin1;
    logic [2:0] sel0;
    logic [2:0] sel1;

    assign sel0 = (int'(src_sel_ff[`F_SRC0_LSB +: 3]) < NUM_RESULTS)
        ? src_sel_ff[`F_SRC0_LSB +: 3] : 3'h0;
    assign sel1 = (int'(src_sel_ff[`F_SRC1_LSB +: 3]) < NUM_RESULTS)
        ? src_sel_ff[`F_SRC1_LSB +: 3] : 3'h0;
    assign src0 = meas_results[sel0*24 +: 24];
    assign src1 = meas_results[sel1*24 +: 24];
    assign lin0 = linearize(slope0_ff, offset0_ff, src0, max0);
    assign lin1 = linearize(slope1_ff, offset1_ff, src1, max1);

    always_ff @(posedge clk) begin
        if (srst) begin
            code0_ff <= '0;
            code1_ff <= '0;
            drop0_ff <= 1'b0;
            drop1_ff <= 1'b0;
        end else if (meas_valid) begin
            drop0_ff <= !lin0[10];
            drop1_ff <= !lin1[10];
            if (lin0[10]) begin
                code0_ff <= lin0[9:0];
            end
            if (lin1[10]) begin
                code1_ff <= lin1[9:0];
            end
        end
    end

    // ------------------------------------------------------------
    // Carrier ticks, exact on average by phase accumulation
    // ------------------------------------------------------------
    localparam int CAR_KHZ [3] = '{`CAR_8M_KHZ, `CAR_1M_KHZ, `CAR_100K_KHZ};
    localparam logic [17:0] CLK_KHZ_W = 18'(`CLK_KHZ);
    logic [2:0] tick_ff;

    genvar g;
    generate
        for (g = 0; g < 3; g++) begin : g_car
            logic [17:0] phase_ff;
            logic [17:0] nxt_phase;
            assign nxt_phase = phase_ff + 18'(CAR_KHZ[g]);
            always_ff @(posedge clk) begin
                if (srst) begin
                    phase_ff <= '0;
                    tick_ff[g] <= 1'b0;
                end else if (nxt_phase >= CLK_KHZ_W) begin
                    phase_ff <= nxt_phase - CLK_KHZ_W;
                    tick_ff[g] <= 1'b1;
                end else begin
                    phase_ff <= nxt_phase;
                    tick_ff[g] <= 1'b0;
                end
            end
        end
    endgenerate

    // ------------------------------------------------------------
    // Modulators
    // ------------------------------------------------------------
    logic pulse_chan_zero;
    logic pulse_chan_one;
    logic tick0;
    logic tick1;

    assign tick0 = pick_tick(gpio_cfg_ff[`F_CAR0_LSB +: 2], tick_ff);
    assign tick1 = pick_tick(gpio_cfg_ff[`F_CAR1_LSB +: 2], tick_ff);

    pulse_modulator u_mod0 (
        .clk(clk),
        .srst(srst),
        .tick(tick0),
        .code_in(code0_ff),
        .max_in(max0),
        .pwm_mode(gpio_cfg_ff[`F_PWM0]),
        .pulse_out(pulse_chan_zero)
    );

    pulse_modulator u_mod1 (
        .clk(clk),
        .srst(srst),
        .tick(tick1),
        .code_in(code1_ff),
        .max_in(max1),
        .pwm_mode(gpio_cfg_ff[`F_PWM1]),
        .pulse_out(pulse_chan_one)
    );

    // ------------------------------------------------------------
    // Input filtering
    // ------------------------------------------------------------
    logic [3:0] in_level;

    generate
        for (g = 0; g < 4; g++) begin : g_deb
            port_debounce #(
                .STABLE_CYCLES(DEBOUNCE_CYCLES)
            ) u_deb (
                .clk(clk),
                .srst(srst),
                .raw_in(port_in[g]),
                .enable(debounce_sel[g]),
                .level_out(in_level[g])
            );
        end
    endgenerate

    // ------------------------------------------------------------
    // Port drivers
    // ------------------------------------------------------------
    logic [5:0] nxt_out;
    logic [5:0] nxt_oe;

    always_comb begin
        nxt_out = gpio_data_ff;
        nxt_oe = {2'b11, ~dir_in[3:0]};
        for (int i = 0; i < 4; i++) begin
            if (route_cd == (i >= 2) && !dir_in[i]) begin
                nxt_out[i] = (i % 2 == 0) ? pulse_chan_zero : pulse_chan_one;
            end
        end
        if (spi_active) begin
            nxt_oe[1:0] = 2'b10;
            nxt_out[1:0] = {spi_data_out, 1'b0};
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            port_out <= '0;
            port_oe <= '0;
            port_pullup_en <= '0;
            spi_select_in <= 1'b1;
        end else begin
            port_out <= nxt_out;
            port_oe <= nxt_oe;
            port_pullup_en <= pullup_sel & dir_in[3:0];
            spi_select_in <= spi_active ? in_level[0] : 1'b1;
        end
    end

    // ------------------------------------------------------------
    // Bus answer: no wait states, settings read as zero
    // ------------------------------------------------------------
    logic [31:0] nxt_rdata;

    always_comb begin
        nxt_rdata = '0;
        if (widx == `IDX_STATUS) begin
            nxt_rdata = {4'h0, drop1_ff, drop0_ff, code1_ff, code0_ff, 2'b00, in_level};
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= '0;
        end else begin
            pready <= psel && !penable && !pready;
            if (psel && !penable) begin
                pslverr <= !addr_ok;
                prdata <= (addr_ok && !pwrite) ? nxt_rdata : 32'h0000_0000;
            end
        end
    end
endmodule // pulse_code_output_ports

// ===== sim/pulse_ports_checker.sv
`timescale 1ns/1ps

module pulse_ports_checker (
    input wire logic clk,
    input wire logic srst,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic spi_active,
    input wire logic [5:0] port_oe,
    input wire logic spi_select_in
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (srst);

    // ------------------------------------------------------------
    // Bus and port relations
    // ------------------------------------------------------------
    a_setup_gets_ready: assert property (psel && !penable |=> pready)
        else $error("no ready after setup");
    a_ready_one_cycle: assert property (pready |=> !pready)
        else $error("ready held too long");
    a_ready_in_access: assert property (pready |-> psel && penable)
        else $error("ready outside access");
    a_cfg_reads_zero: assert property (pready && !pwrite && paddr != 8'h80 |-> prdata == 32'h0)
        else $error("write-only register read back data");
    a_unmapped_err: assert property (psel && !penable && paddr == 8'hfc |=> pready && pslverr)
        else $error("unmapped index not refused");
    a_ef_always_out: assert property (!$past(srst) |-> port_oe[5:4] == 2'b11)
        else $error("output-only ports not driven");
    a_spi_owns_ab: assert property (spi_active ##1 spi_active |=> port_oe[1:0] == 2'b10)
        else $error("serial mode port directions wrong");
    a_select_idle: assert property (!spi_active |=> spi_select_in)
        else $error("select high expected outside serial mode");

    c_refused: cover property (pready && pslverr);
    c_write: cover property (pready && pwrite);
    c_serial: cover property (spi_active ##1 spi_active);
endmodule // pulse_ports_checker

bind pulse_code_output_ports pulse_ports_checker u_chk (.clk(clk), .srst(srst), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .spi_active(spi_active), .port_oe(port_oe),
    .spi_select_in(spi_select_in));

// ===== sim/lpf_model.sv
`timescale 1ns/1ps

// Filter side: counts high time and high-run lengths of the pulse stream
module lpf_model (
    input wire logic clk,
    input wire logic srst,
    input wire logic clear,
    input wire logic pulse_in,
    output logic [31:0] run_len,
    output logic [31:0] n_runs,
    output logic [31:0] max_run,
    output logic [31:0] ones
);
    logic [31:0] cur;
    always @(posedge clk) begin
        if (srst || clear) begin
            cur <= 32'h0;
            run_len <= 32'h0;
            n_runs <= 32'h0;
            max_run <= 32'h0;
            ones <= 32'h0;
        end else if (pulse_in) begin
            cur <= cur + 32'h1;
            ones <= ones + 32'h1;
        end else if (cur != 32'h0) begin
            run_len <= cur;
            n_runs <= n_runs + 32'h1;
            if (cur > max_run) max_run <= cur;
            cur <= 32'h0;
        end
    end
endmodule // lpf_model

// ===== sim/pulse_code_output_ports_tb_top.sv
`timescale 1ns/1ps
`include "pulse_defs.svh"

module pulse_code_output_ports_tb_top;
    import pulse_pkg::*;
    logic clk = 1'b0;
    logic srst = 1'b1;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic [191:0] meas_results = '0;
    logic meas_valid = 1'b0;
    logic spi_active = 1'b0;
    logic spi_data_out = 1'b0;
    logic [5:0] port_in = 6'h3f;
    logic clr = 1'b0;
    logic [31:0] prdata, rd, len0, runs0, max0, ones0, ones1;
    logic pready, pslverr, err, spi_select_in;
    logic [5:0] port_out, port_oe;
    logic [3:0] port_pullup_en;
    int fails = 0;
    int samples_checked = 0;
    int cyc = 0;
    int khz[3] = '{`CAR_8M_KHZ, `CAR_1M_KHZ, `CAR_100K_KHZ};
    int e;

    always #4 clk = ~clk;

    pulse_code_output_ports #(.NUM_RESULTS(8), .DEBOUNCE_CYCLES(4)) u_dut (.clk(clk),
        .srst(srst), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .meas_results(meas_results), .meas_valid(meas_valid), .spi_active(spi_active),
        .spi_data_out(spi_data_out), .port_in(port_in), .port_out(port_out),
        .port_oe(port_oe), .port_pullup_en(port_pullup_en), .spi_select_in(spi_select_in));

    lpf_model u_lpf0 (.clk(clk), .srst(srst), .clear(clr), .pulse_in(port_out[0]),
        .run_len(len0), .n_runs(runs0), .max_run(max0), .ones(ones0));
    lpf_model u_lpf1 (.clk(clk), .srst(srst), .clear(clr), .pulse_in(port_out[1]),
        .run_len(), .n_runs(), .max_run(), .ones(ones1));

    task final_report;
        $display("checked %0d fails %0d", samples_checked, fails);
        if (fails == 0 && samples_checked > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask

    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 95000) begin
            fails = fails + 1;
            final_report();
        end
    end

    task check(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp) begin
            fails++;
            $display("BAD %0t got %h expected %h", $time, got, exp);
        end
    endtask

    // ------------------------------------------------------------
    // Bus, measurement and filter helpers
    // ------------------------------------------------------------
    task apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        do begin
            @(posedge clk);
        end while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clk);
    endtask

    task status;
        apb(1'b0, `IDX_STATUS * 4, 32'h0);
    endtask

    task set_cfg(input logic [5:0] dir, input logic [3:0] pu, input logic [3:0] db,
                 input logic rt, input logic [1:0] car, input logic [2:0] res, input logic pwm);
        apb(1'b1, `IDX_GPIO_CFG * 4, {5'h0, 1'b0, pwm, res, res, 2'b00, car, rt, db, pu, dir});
    endtask

    task meas(input logic [23:0] r0, input logic [23:0] r1);
        meas_results[24+:24] <= r0;
        meas_results[48+:24] <= r1;
        meas_valid <= 1'b1;
        @(posedge clk);
        meas_valid <= 1'b0;
        repeat (3) @(posedge clk);
    endtask

    task clear_filters;
        clr <= 1'b1;
        @(posedge clk);
        clr <= 1'b0;
        @(posedge clk);
    endtask

    task wait_runs(input int n);
        while (runs0 < n) @(posedge clk);
    endtask

    initial begin
        repeat (16) @(posedge clk);
        srst <= 1'b0;
        @(posedge clk);
        apb(1'b0, `IDX_GPIO_CFG * 4, 32'h0);
        check(rd, 32'h0);
        apb(1'b0, 8'hfc, 32'h0);
        check({31'h0, err}, 32'h1);
        $display("test register map done");
        set_cfg(6'b111100, 4'h0, 4'h0, 1'b0, 2'd0, 3'd0, 1'b0);
        apb(1'b1, `IDX_SRC_SEL * 4, 32'h11);
        apb(1'b1, `IDX_SLOPE0 * 4, 32'h01_0000);
        apb(1'b1, `IDX_OFFSET0 * 4, 32'h0);
        apb(1'b1, `IDX_SLOPE1 * 4, 32'hff_0000);
        apb(1'b1, `IDX_OFFSET1 * 4, 32'h3ff);
        meas(24'd500, 24'd100);
        status();
        check(rd[25:6], {10'd923, 10'd500});
        meas(24'd1023, 24'd1024);
        status();
        check(rd[27:6], {2'b10, 10'd923, 10'd1023});
        meas(24'd1024, 24'd0);
        status();
        check(rd[27:6], {2'b01, 10'd1023, 10'd1023});
        $display("test linear map done");
        set_cfg(6'b111100, 4'h0, 4'h0, 1'b0, 2'd0, 3'd6, 1'b0);
        meas(24'd0, 24'd1008);
        // First period still runs at the reset width of 1023 ticks
        repeat (16400) @(posedge clk);
        clear_filters();
        repeat (240) @(posedge clk);
        check(ones0, 32'h0);
        check({31'h0, ones1 > 235}, 32'h1);
        meas(24'd16, 24'd1008);
        status();
        check(rd[26:6], {1'b1, 10'd15, 10'd0});
        $display("test full scale done");
        for (int k = 0; k < 3; k++) begin
            set_cfg(6'b111100, 4'h0, 4'h0, 1'b0, 2'(k), 3'd6, 1'b1);
            meas(24'd8, 24'd1008);
            clear_filters();
            wait_runs(2);
            e = 8 * `CLK_KHZ / khz[k];
            check({31'h0, len0 + 2 >= e && len0 <= e + 2}, 32'h1);
        end
        set_cfg(6'b111100, 4'h0, 4'h0, 1'b0, 2'd1, 3'd6, 1'b0);
        repeat (2000) @(posedge clk);
        clear_filters();
        wait_runs(6);
        check({31'h0, max0 <= 252}, 32'h1);
        $display("test carriers done");
        set_cfg(6'b111011, 4'b0011, 4'b0001, 1'b1, 2'd0, 3'd6, 1'b0);
        repeat (3) @(posedge clk);
        check(port_oe[3:0], 4'b0100);
        check(port_pullup_en, 4'b0011);
        port_in[0] <= 1'b0;
        repeat (2) @(posedge clk);
        status();
        check(rd[0], 1'b1);
        repeat (12) @(posedge clk);
        status();
        check(rd[0], 1'b0);
        $display("test routing done");
        spi_active <= 1'b1;
        spi_data_out <= 1'b1;
        repeat (4) @(posedge clk);
        check(port_oe[1:0], 2'b10);
        check(port_out[1], 1'b1);
        spi_data_out <= 1'b0;
        repeat (4) @(posedge clk);
        check(port_out[1], 1'b0);
        check(spi_select_in, 1'b0);
        spi_active <= 1'b0;
        $display("test serial ports done");
        final_report();
    end
endmodule // pulse_code_output_ports_tb_top
